// ### logic/wmb_defines.svh
// Constants for the wide multiply and bitfield unit.
// Assumes a 32-bit word and a 64-bit long value.
`ifndef WMB_DEFINES_SVH
`define WMB_DEFINES_SVH
`define WMB_BPW       6'd32
`define WMB_OPC_W     3
`define WMB_OPC_LATE  3'h0
`define WMB_OPC_LMUL  3'h1
`define WMB_OPC_LSATS 3'h2
`define WMB_OPC_LEXT  3'h3
`define WMB_OPC_LINS  3'h4
`define WMB_OPC_MAC   3'h5
`define WMB_OPC_MACS  3'h6
`define WMB_RST_WORD  32'h0000_0000
`define WMB_RESULT_LATENCY 1
`endif

// ### logic/wmb_field.sv
// Combinational 64-bit bitfield extract and insert.
// Assumes position and length are legal values from the issuing core.
`timescale 1ns/10ps
module wmb_field
    import wmb_pkg::*;
(
    input  wire logic [63:0] value_i,
    input  wire logic [31:0] field_i,
    input  wire logic [5:0]  pos_i,
    input  wire logic [5:0]  len_i,
    output logic      [31:0] extract_o,
    output logic      [63:0] insert_o
);
    logic [63:0] mask;
    logic [63:0] shifted;
    logic [63:0] field_mask;

    always_comb begin
        // Length of zero or above a word is taken as a full word
        if (len_i == 6'd0 || len_i >= `WMB_BPW) begin
            mask = 64'h0000_0000_ffff_ffff;
        end else begin
            mask = (64'h1 << len_i) - 64'h1;
        end
        shifted    = value_i >> pos_i;
        extract_o  = shifted[31:0] & mask[31:0];
        field_mask = mask << pos_i;
        insert_o   = (value_i & ~field_mask) |
                     (({32'h0, field_i} & mask) << pos_i);
    end
endmodule

// ### logic/wmb_pkg.sv
// Types for the wide multiply and bitfield unit.
// Assumes wmb_defines.svh is on the include path.
`include "wmb_defines.svh"
package wmb_pkg;
    typedef enum logic [6:0] {
        WMB_LATE  = 7'h01,
        WMB_LMUL  = 7'h02,
        WMB_LSATS = 7'h04,
        WMB_LEXT  = 7'h08,
        WMB_LINS  = 7'h10,
        WMB_MAC   = 7'h20,
        WMB_MACS  = 7'h40
    } wmb_op_e;
    typedef logic [31:0] wmb_word_t;
    typedef logic [63:0] wmb_long_t;
endpackage

// ### logic/wmb_unit.sv
// Wide multiply, accumulate, saturate, bitfield and late-time unit.
// Assumes the issuing core holds operands stable while start_i is high.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
module wmb_unit
    import wmb_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        start_i,
    input  wire logic [2:0]  opcode_i,
    input  wire logic [31:0] op_a_i,
    input  wire logic [31:0] op_b_i,
    input  wire logic [31:0] op_c_i,
    input  wire logic [31:0] op_d_i,
    input  wire logic [31:0] ref_time_i,
    output logic             valid_o,
    output logic             call_exception_type_o,
    output logic      [31:0] res_hi_o,
    output logic      [31:0] res_lo_o
);
    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic wmb_long_t join_words(input wmb_word_t hi,
                                             input wmb_word_t lo);
        join_words = {hi, lo};
    endfunction

    function automatic wmb_long_t umul(input wmb_word_t x,
                                       input wmb_word_t y);
        umul = {32'h0, x} * {32'h0, y};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Operation decode
    wmb_op_e op;
    always_comb begin
        case (opcode_i)
            `WMB_OPC_LATE:  op = WMB_LATE;
            `WMB_OPC_LMUL:  op = WMB_LMUL;
            `WMB_OPC_LSATS: op = WMB_LSATS;
            `WMB_OPC_LEXT:  op = WMB_LEXT;
            `WMB_OPC_LINS:  op = WMB_LINS;
            `WMB_OPC_MAC:   op = WMB_MAC;
            `WMB_OPC_MACS:  op = WMB_MACS;
            default:        op = WMB_LMUL;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Datapath
    wmb_long_t   lmul_res;
    wmb_long_t   mac_res;
    wmb_long_t   macs_res;
    wmb_long_t   sat_res;
    wmb_long_t   long_val;
    logic [31:0] ext_res;
    wmb_long_t   ins_res;
    logic        late_hit;

    assign long_val = join_words(op_b_i, op_a_i);

    wmb_field u_field (
        .value_i   (long_val),
        .field_i   (op_c_i),
        .pos_i     (op_d_i[5:0]),
        .len_i     (ref_time_i[5:0]),
        .extract_o (ext_res),
        .insert_o  (ins_res)
    );

    logic signed [63:0] sprod;
    logic signed [63:0] sacc;
    logic signed [63:0] sval;
    logic signed [63:0] shi_lim;
    logic signed [63:0] slo_lim;
    logic        [5:0]  sidx;

    always_comb begin
        lmul_res = umul(op_a_i, op_b_i) + {32'h0, op_c_i}
                   + {32'h0, op_d_i};
        mac_res  = umul(op_a_i, op_b_i)
                   + join_words(op_c_i, op_d_i);
        sprod    = $signed(op_a_i) * $signed(op_b_i);
        // High word signed, low word zero-extended
        sacc     = $signed({op_c_i, op_d_i});
        macs_res = $unsigned(sprod + sacc);
        // Saturate: value must fit in 64-index signed bits
        sidx     = op_c_i[5:0];
        sval     = $signed(long_val);
        shi_lim  = 64'sh7fff_ffff_ffff_ffff >>> sidx;
        slo_lim  = $signed(64'h8000_0000_0000_0000) >>> sidx;
        if (sval > shi_lim) begin
            sat_res = $unsigned(shi_lim);
        end else if (sval < slo_lim) begin
            sat_res = $unsigned(slo_lim);
        end else begin
            sat_res = long_val;
        end
        late_hit = op_a_i < ref_time_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Result registers
    logic        valid_ff;
    logic        exc_ff;
    logic [31:0] hi_ff;
    logic [31:0] lo_ff;
    logic        nxt_valid;
    logic        nxt_exc;
    logic [31:0] nxt_hi;
    logic [31:0] nxt_lo;

    always_comb begin
        nxt_valid = start_i;
        nxt_exc   = 1'b0;
        nxt_hi    = hi_ff;
        nxt_lo    = lo_ff;
        if (start_i) begin
            case (op)
                WMB_LATE: begin
                    nxt_exc = late_hit;
                    nxt_hi  = `WMB_RST_WORD;
                    nxt_lo  = `WMB_RST_WORD;
                end
                WMB_LMUL: begin
                    {nxt_hi, nxt_lo} = lmul_res;
                end
                WMB_LSATS: begin
                    {nxt_hi, nxt_lo} = sat_res;
                end
                WMB_LEXT: begin
                    nxt_hi = `WMB_RST_WORD;
                    nxt_lo = ext_res;
                end
                WMB_LINS: begin
                    {nxt_hi, nxt_lo} = ins_res;
                end
                WMB_MAC: begin
                    {nxt_hi, nxt_lo} = mac_res;
                end
                WMB_MACS: begin
                    {nxt_hi, nxt_lo} = macs_res;
                end
                default: begin
                    {nxt_hi, nxt_lo} = lmul_res;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            valid_ff <= 1'b0;
            exc_ff   <= 1'b0;
            hi_ff    <= `WMB_RST_WORD;
            lo_ff    <= `WMB_RST_WORD;
        end else begin
            valid_ff <= nxt_valid;
            exc_ff   <= nxt_exc;
            hi_ff    <= nxt_hi;
            lo_ff    <= nxt_lo;
        end
    end

    assign valid_o               = valid_ff;
    assign call_exception_type_o = exc_ff;
    assign res_hi_o              = hi_ff;
    assign res_lo_o              = lo_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_issue_lmul;
        start_i && opcode_i == `WMB_OPC_LMUL;
    endsequence

    property p_lmul;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_issue_lmul |=> {res_hi_o, res_lo_o} ==
            $past(umul(op_a_i, op_b_i) + {32'h0, op_c_i} + {32'h0, op_d_i});
    endproperty
    a_lmul: assert property (p_lmul)
        else $error("lmul result wrong");

    property p_mac;
        @(posedge clk_i) disable iff (!rst_n_i)
        start_i && opcode_i == `WMB_OPC_MAC |=> {res_hi_o, res_lo_o} ==
            $past(umul(op_a_i, op_b_i) + {op_c_i, op_d_i});
    endproperty
    a_mac: assert property (p_mac)
        else $error("mac result wrong");

    property p_macs;
        @(posedge clk_i) disable iff (!rst_n_i)
        start_i && opcode_i == `WMB_OPC_MACS |=> {res_hi_o, res_lo_o} ==
            $past($unsigned($signed(op_a_i) * $signed(op_b_i)
                  + $signed({op_c_i, op_d_i})));
    endproperty
    a_macs: assert property (p_macs)
        else $error("macs result wrong");

    property p_macs_lo_unsigned;
        @(posedge clk_i) disable iff (!rst_n_i)
        start_i && opcode_i == `WMB_OPC_MACS && op_a_i == 32'h0
            |=> res_lo_o == $past(op_d_i) && res_hi_o == $past(op_c_i);
    endproperty
    a_macs_lo_unsigned: assert property (p_macs_lo_unsigned)
        else $error("macs accumulator sign handling wrong");

    property p_late;
        @(posedge clk_i) disable iff (!rst_n_i)
        start_i && opcode_i == `WMB_OPC_LATE
            |=> call_exception_type_o == $past(op_a_i < ref_time_i);
    endproperty
    a_late: assert property (p_late)
        else $error("late check wrong");

    property p_no_exc;
        @(posedge clk_i) disable iff (!rst_n_i)
        !(start_i && opcode_i == `WMB_OPC_LATE) |=> !call_exception_type_o;
    endproperty
    a_no_exc: assert property (p_no_exc)
        else $error("spurious call exception");

    property p_sat_pass;
        @(posedge clk_i) disable iff (!rst_n_i)
        start_i && opcode_i == `WMB_OPC_LSATS && op_c_i[5:0] == 6'd0
            |=> {res_hi_o, res_lo_o} == $past({op_b_i, op_a_i});
    endproperty
    a_sat_pass: assert property (p_sat_pass)
        else $error("saturate at index zero changed value");

    property p_ext;
        @(posedge clk_i) disable iff (!rst_n_i)
        start_i && opcode_i == `WMB_OPC_LEXT && ref_time_i[5:0] == 6'd8
            |=> res_lo_o == {24'h0, 8'($past(long_val >> op_d_i[5:0]))}
                && res_hi_o == 32'h0;
    endproperty
    a_ext: assert property (p_ext)
        else $error("extract result wrong");

    property p_valid;
        @(posedge clk_i) disable iff (!rst_n_i)
        start_i ##1 !start_i |-> valid_o ##1 !valid_o;
    endproperty
    a_valid: assert property (p_valid)
        else $error("valid timing wrong");
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the wide multiply and bitfield unit.
// Assumes the core model drives all unit inputs except clock and reset.
`timescale 1ns/10ps
`include "wmb_defines.svh"
module tb_top;
    import wmb_pkg::*;
    logic             clk_i = 1'b0;
    logic             rst_n_i = 1'b0;
    logic             start, vld, exc;
    logic      [2:0]  opc;
    logic      [31:0] a, b, c, d, r, hi, lo;
    logic      [63:0] last;
    int               err_total = 0;
    int               total_checks = 0;
    always #5 clk_i = ~clk_i;
    wmb_core_model u_core (.clk_i(clk_i), .start_o(start), .opcode_o(opc),
        .a_o(a), .b_o(b), .c_o(c), .d_o(d), .r_o(r));
    wmb_unit u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start),
        .opcode_i(opc), .op_a_i(a), .op_b_i(b), .op_c_i(c), .op_d_i(d),
        .ref_time_i(r), .valid_o(vld), .call_exception_type_o(exc),
        .res_hi_o(hi), .res_lo_o(lo));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic out(input logic [63:0] e, input logic v, input logic x);
        chk({hi, lo}, e);
        chk({62'h0, vld, exc}, {62'h0, v, x});
        last = e;
    endtask
    task automatic results();
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_arith();
        logic [31:0] x, y, z;
        u_core.issue(`WMB_OPC_LMUL, '1, '1, '1, '1, '0);
        out(64'hffff_ffff_ffff_ffff, 1'b1, 1'b0);
        x = 32'h1234_5678;
        y = 32'h9abc_def0;
        u_core.issue(`WMB_OPC_LMUL, x, y, 32'h1, 32'h2, '0);
        out({32'h0, x} * {32'h0, y} + 64'h3, 1'b1, 1'b0);
        // Spare opcode falls back to multiply add
        u_core.issue(3'h7, x, y, 32'h1, 32'h2, '0);
        out({32'h0, x} * {32'h0, y} + 64'h3, 1'b1, 1'b0);
        u_core.issue(`WMB_OPC_MAC, '1, '1, '1, x, '0);
        out(64'hffff_fffe_0000_0001 + {32'hffff_ffff, x}, 1'b1, 1'b0);
        z = 32'hffff_fffe;
        u_core.issue(`WMB_OPC_MACS, z, 32'h3, 32'h0, 32'h1, '0);
        out(64'hffff_ffff_ffff_fffb, 1'b1, 1'b0);
        u_core.issue(`WMB_OPC_MACS, z, y, '1, 32'h8000_0000, '0);
        out({{32{z[31]}}, z} * {{32{y[31]}}, y} + {32'hffff_ffff,
            32'h8000_0000}, 1'b1, 1'b0);
        // Zero product: low word with top bit set must not borrow
        u_core.issue(`WMB_OPC_MACS, '0, y, x, 32'h8000_0001, '0);
        out({x, 32'h8000_0001}, 1'b1, 1'b0);
    endtask
    task automatic t_late();
        u_core.issue(`WMB_OPC_LATE, 32'h5, '0, '0, '0, 32'h6);
        out(64'h0, 1'b1, 1'b1);
        u_core.issue(`WMB_OPC_LATE, 32'h6, '0, '0, '0, 32'h6);
        out(64'h0, 1'b1, 1'b0);
        u_core.issue(`WMB_OPC_LATE, '1, '0, '0, '0, 32'h0);
        out(64'h0, 1'b1, 1'b0);
    endtask
    task automatic t_sats();
        logic signed [63:0] v[3];
        logic signed [63:0] mx, mn, e;
        v = '{64'sh0000_8000_0000_0000, 64'shffff_0000_0000_0000,
              64'sh0000_1234_5678_9abc};
        mx = 64'sh7fff_ffff_ffff_ffff >>> 16;
        mn = 64'sh8000_0000_0000_0000 >>> 16;
        foreach (v[i]) begin
            e = v[i] > mx ? mx : (v[i] < mn ? mn : v[i]);
            u_core.issue(`WMB_OPC_LSATS, v[i][31:0], v[i][63:32], 32'h10,
                         '0, '0);
            out(e, 1'b1, 1'b0);
        end
        // Index zero never saturates
        u_core.issue(`WMB_OPC_LSATS, v[0][31:0], v[0][63:32], 32'h0,
                     '0, '0);
        out(v[0], 1'b1, 1'b0);
    endtask
    task automatic t_field();
        logic [5:0]  lens[11];
        logic [63:0] v, m;
        logic [31:0] f;
        logic [4:0]  p;
        lens = '{6'd1, 6'd2, 6'd3, 6'd4, 6'd5, 6'd6, 6'd7, 6'd8,
                 6'd16, 6'd24, 6'd32};
        v = 64'hfedc_ba98_7654_3210;
        f = 32'ha5a5_5a5f;
        foreach (lens[i]) begin
            p = (i == 10) ? 5'd31 : 5'(i * 3);
            m = ((64'h1 << lens[i]) - 64'h1) << p;
            u_core.field(`WMB_OPC_LEXT, v, f, p, lens[i]);
            out((v & m) >> p, 1'b1, 1'b0);
            u_core.field(`WMB_OPC_LINS, v, f, p, lens[i]);
            out((v & ~m) | (({32'h0, f} << p) & m), 1'b1, 1'b0);
        end
    endtask
    task automatic t_idle_reset();
        u_core.idle();
        out(last, 1'b0, 1'b0);
        rst_n_i = 1'b0;
        #1;
        out(64'h0, 1'b0, 1'b0);
        @(negedge clk_i);
        rst_n_i = 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #3000;
        err_total++;
        results();
    end
    initial begin
        repeat (4) @(negedge clk_i);
        out(64'h0, 1'b0, 1'b0);
        rst_n_i = 1'b1;
        t_arith();
        t_late();
        t_sats();
        t_field();
        t_idle_reset();
        t_late();
        results();
    end
endmodule

// ### tb/wmb_core_model.sv
// Issuing core model: drives one operation per call at the falling edge.
// Assumes the caller enters each task at a falling edge of clk_i.
`timescale 1ns/10ps
module wmb_core_model (
    input  wire logic        clk_i,
    output logic             start_o,
    output logic      [2:0]  opcode_o,
    output logic      [31:0] a_o,
    output logic      [31:0] b_o,
    output logic      [31:0] c_o,
    output logic      [31:0] d_o,
    output logic      [31:0] r_o
);
    initial begin
        start_o  = 1'b0;
        opcode_o = 3'h0;
        {a_o, b_o, c_o, d_o, r_o} = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Start stays high so calls run back to back
    task automatic issue(input logic [2:0] op, input logic [31:0] a, b, c,
                         input logic [31:0] d, r);
        start_o  = 1'b1;
        opcode_o = op;
        {a_o, b_o, c_o, d_o, r_o} = {a, b, c, d, r};
        @(negedge clk_i);
    endtask
    // Position limited to one word, length from the legal list only
    task automatic field(input logic [2:0] op, input logic [63:0] v,
                         input logic [31:0] f, input logic [4:0] pos,
                         input logic [5:0] len);
        issue(op, v[31:0], v[63:32], f, {27'h0, pos},
              {26'h0, len});
    endtask
    task automatic idle();
        start_o = 1'b0;
        @(negedge clk_i);
    endtask
endmodule
